// ==== core/adc_pkg.sv ====
// Package for the converter control and result port.
// Assumes a single 50 MHz core clock; all times become cycle counts here.
package adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the AHB-Lite slave)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;

  // Control word layout, bit 7 first
  typedef struct packed {
    logic soft_reset;
    logic ref_buffer_off;
    logic internal_ref_off;
    logic power_down_request;
    logic frame_marker_invert;
    logic serial_clock_invert;
    logic clock_source_select;
    logic interface_select;
  } ctrl_t;
  localparam logic [7:0] CTRL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACQ_NS = 1000;
  localparam int CONV_NS = 8000;
  localparam int SCLK_HALF_NS = 80;
  // Least times round up to whole cycles
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] ACQ_LAST = 10'(ACQ_CYC - 1);
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYC - 1);
  localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] SER_BITS = 5'h10;
  localparam logic [4:0] SER_LAST = 5'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Pin bit positions in the shared result bus
  localparam int PIN_SDATA = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_MARK = 10;
  localparam int PIN_OVR = 11;

  // Pin inputs as they cross into the core clock domain
  typedef struct packed {
    logic convert_start_n;
    logic sclk;
    logic cs_n;
    logic rd_n;
    logic read_timing_or_chain_in;
  } pin_in_t;
  localparam int PIN_IN_W = 5;

  // Conversion sequencer states
  typedef enum logic [2:0] {
    ST_ACQ = 3'b000,
    ST_WAIT_FALL = 3'b001,
    ST_CONV = 3'b010,
    ST_PD = 3'b011
  } conv_state_t;

endpackage

// ==== core/sync_bank.sv ====
// Bank of two-flop synchronisers for asynchronous pin inputs.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/100ps
module sync_bank #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage, never other logic
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta;
    always_ff @(posedge clk) begin
      if (srst) begin
        meta <= 1'b1;
        q[i] <= 1'b1;
      end else begin
        meta <= d[i];
        q[i] <= meta;
      end
    end
  end

endmodule

// ==== core/adc_port.sv ====
// Conversion sequencer and parallel/serial result port with AHB-Lite control.
// Assumes pin inputs are asynchronous and sar_code is valid at conversion end.
`timescale 1ns/100ps

module adc_port import adc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Converter pins
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic read_timing_or_chain_in,
  input wire logic sclk_in,
  // Analog core result
  input wire logic [15:0] sar_code,
  // Result bus (pin 9 doubles as serial clock)
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  // Status and analog controls
  output logic busy,
  output logic sample_hold,
  output logic ref_enable,
  output logic ref_buffer_enable,
  output logic low_power
);

  ctrl_t ctrl;
  conv_state_t state;
  pin_in_t pin_raw;
  pin_in_t pin_s;
  logic [PIN_IN_W-1:0] pin_q;
  logic rst;
  logic [9:0] cnt;
  logic cnv_prev;
  logic cnv_fall;
  logic conv_start;
  logic conv_done;
  logic [15:0] result;
  logic [15:0] shreg;
  logic [4:0] bit_cnt;
  logic int_active;
  logic sclk_int;
  logic [2:0] div_cnt;
  logic tick;
  logic sclk_prev;
  logic ext_edge;
  logic ext_active;
  logic ovr_pulse;
  logic [7:0] ovr_count;
  logic ser_int;
  logic ser_ext;
  logic out_en;
  logic wr_pend;
  logic [7:0] addr_q;
  logic acc;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  assign pin_raw = '{convert_start_n: convert_start_n, sclk: sclk_in, cs_n: cs_n,
                     rd_n: rd_n, read_timing_or_chain_in: read_timing_or_chain_in};

  sync_bank #(.WIDTH(PIN_IN_W)) u_sync (
    .clk(ref_clk),
    .srst(srst),
    .d(pin_raw),
    .q(pin_q)
  );
  assign pin_s = pin_q;

  // Soft reset bit resets the sequencer, shifter and pin drivers while it is set; bus, control and reference logic see only srst
  assign rst = srst | ctrl.soft_reset;
  assign ser_int = ctrl.interface_select & ~ctrl.clock_source_select;
  assign ser_ext = ctrl.interface_select & ctrl.clock_source_select;
  assign out_en = ~pin_s.cs_n & ~pin_s.rd_n;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign acc = hsel & hready & htrans[1];

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFS: rd_word = {24'h00_0000, ctrl};
      STATUS_OFS: rd_word = {16'h0000, ovr_count, 2'b00, state, ext_active,
                             int_active, busy};
      RESULT_OFS: rd_word = {16'h0000, result};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= acc & hwrite;
      if (acc) begin
        addr_q <= haddr[7:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
    end else if (wr_pend && addr_q == CTRL_OFS) begin
      ctrl <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnv_prev <= 1'b1;
    end else begin
      cnv_prev <= pin_s.convert_start_n;
    end
  end
  assign cnv_fall = cnv_prev & ~pin_s.convert_start_n;

  assign conv_start = (state == ST_ACQ && cnt == ACQ_LAST && !ctrl.power_down_request
                       && !pin_s.convert_start_n)
                    || (state == ST_WAIT_FALL && cnv_fall && !ctrl.power_down_request);
  assign conv_done = (state == ST_CONV) && (cnt == CONV_LAST);

  // Power-down is only looked at outside a conversion, so a running one ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_ACQ;
      cnt <= 10'h000;
    end else begin
      case (state)
        ST_ACQ: begin
          cnt <= cnt + 10'h001;
          if (cnt == ACQ_LAST) begin
            cnt <= 10'h000;
            if (ctrl.power_down_request) begin
              state <= ST_PD;
            end else if (!pin_s.convert_start_n) begin
              state <= ST_CONV;
            end else begin
              state <= ST_WAIT_FALL;
            end
          end
        end
        ST_WAIT_FALL: begin
          if (ctrl.power_down_request) begin
            state <= ST_PD;
          end else if (cnv_fall) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          cnt <= cnt + 10'h001;
          if (conv_done) begin
            cnt <= 10'h000;
            state <= ST_ACQ;
          end
        end
        ST_PD: begin
          if (!ctrl.power_down_request) begin
            state <= ST_ACQ;
          end
        end
        default: state <= ST_ACQ;
      endcase
    end
  end

  // Busy spans start to result load; the host may use its fall as data ready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      sample_hold <= 1'b0;
      low_power <= 1'b0;
      result <= 16'h0000;
    end else begin
      if (conv_start) begin
        busy <= 1'b1;
      end else if (conv_done) begin
        busy <= 1'b0;
      end
      sample_hold <= conv_start | (state == ST_CONV && !conv_done);
      low_power <= (state == ST_PD);
      if (conv_done) begin
        result <= sar_code;
      end
    end
  end

  // Reference controls follow their bits directly
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_enable <= 1'b1;
      ref_buffer_enable <= 1'b1;
    end else begin
      ref_enable <= ~ctrl.internal_ref_off;
      ref_buffer_enable <= ~ctrl.ref_buffer_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clocking: internal divider and external edge detect
  assign tick = (div_cnt == DIV_LAST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 3'h0;
      sclk_prev <= pin_s.sclk; // Tracks the pin through reset, so no false edge
    end else begin
      div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
      sclk_prev <= pin_s.sclk;
    end
  end

  // Edges seen while select is high are dropped
  assign ext_edge = ser_ext && !pin_s.cs_n
                 && (ctrl.serial_clock_invert ? (sclk_prev & ~pin_s.sclk)
                                              : (~sclk_prev & pin_s.sclk));
  assign ext_active = (bit_cnt != 5'h00) && (bit_cnt != SER_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Shift register; a new load always wins over a shift in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
      int_active <= 1'b0;
      sclk_int <= 1'b0;
    end else if (conv_done) begin
      shreg <= sar_code;
      bit_cnt <= 5'h00;
      // Read-after-conversion starts with the fresh result
      int_active <= ser_int & ~pin_s.read_timing_or_chain_in;
      sclk_int <= 1'b0;
    end else if (conv_start && ser_int && pin_s.read_timing_or_chain_in) begin
      shreg <= result; // Read-during-conversion resends the last result
      bit_cnt <= 5'h00;
      int_active <= 1'b1;
      sclk_int <= 1'b0;
    end else if (int_active && tick) begin
      sclk_int <= ~sclk_int;
      if (sclk_int) begin
        shreg <= {shreg[14:0], 1'b0};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == SER_LAST) begin
          int_active <= 1'b0;
        end
      end
    end else if (ext_edge) begin
      // Chain input enters at the bottom and emerges after 16 edges
      shreg <= {shreg[14:0], pin_s.read_timing_or_chain_in};
      if (bit_cnt != SER_BITS) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Overrun: old result was dropped by the load above
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovr_pulse <= 1'b0;
      ovr_count <= 8'h00;
    end else begin
      ovr_pulse <= conv_done & ser_ext & ext_active;
      if (conv_done && ser_ext && ext_active) begin
        ovr_count <= ovr_count + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered; released unless select and read are both low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out <= 16'h0000;
      data_oe <= 16'h0000;
    end else if (!ctrl.interface_select) begin
      data_out <= result;
      data_oe <= {16{out_en}};
    end else begin
      data_out <= result;
      data_out[PIN_SDATA] <= shreg[15];
      data_out[PIN_SCLK] <= sclk_int;
      data_out[PIN_MARK] <= int_active ^ ctrl.frame_marker_invert;
      data_out[PIN_OVR] <= ctrl.clock_source_select ? ovr_pulse : result[PIN_OVR];
      data_oe <= {{4{out_en}}, 4'h0, 8'h00};
      data_oe[PIN_SDATA] <= out_en;
      data_oe[PIN_SCLK] <= out_en & ~ctrl.clock_source_select;
      data_oe[PIN_MARK] <= out_en;
      data_oe[PIN_OVR] <= out_en;
    end
  end

endmodule

// ==== verif/adc_port_assertions.sv ====
// Checker for the converter pins of adc_port.
// Assumes it sees only the ports of adc_port.
`timescale 1ns/100ps
module adc_port_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Watched pins
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic low_power,
  input wire logic [15:0] data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // A conversion opens on busy rising and closes 400 cycles later
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_done;
    ##[399:401] $fell(busy);
  endsequence
  a_busy_len: assert property (s_start |-> s_done)
    else $error("busy length off");
  // Pin path is two flops plus the decision, so low 2 to 4 samples back
  a_start_low: assert property (s_start |->
    !($past(convert_start_n, 2) && $past(convert_start_n, 3) && $past(convert_start_n, 4)))
    else $error("start not low");
  a_hold_set: assert property (s_start |-> ##[0:1] sample_hold)
    else $error("no hold");
  a_pd_idle: assert property (low_power |-> !busy)
    else $error("busy in power-down");
  a_oe_gate: assert property ((cs_n || rd_n) [*4] |-> data_oe == 16'h0000)
    else $error("driven while deselected");
  a_upper_out: assert property (|data_oe |-> &data_oe[15:12])
    else $error("upper pins off");
  a_par_all: assert property (data_oe[7] |-> &data_oe)
    else $error("parallel bus partial");
  a_reset_quiet: assert property ($fell(srst) |-> !busy && data_oe == 16'h0000)
    else $error("not quiet after reset");
endmodule
bind adc_port adc_port_assertions adc_port_assertions_i (.ref_clk, .srst, .convert_start_n,
  .cs_n, .rd_n, .busy, .sample_hold, .low_power, .data_oe);

// ==== verif/host_model.sv ====
// Host that reads results in parallel or over either serial clock.
// Assumes the bench picks the mode and starts reads after busy falls.
`timescale 1ns/100ps
module host_model (
  // Clock and mode
  input wire logic ref_clk,
  input wire logic int_mode,
  input wire logic mark_inv,
  // Device pins
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  output logic cs_n,
  output logic rd_n,
  output logic sclk,
  // Received word
  output logic [15:0] word,
  output logic valid
);
  logic [4:0] cnt;
  logic clk_q;
  logic take;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk = 1'b0;
    valid = 1'b0;
    word = 16'h0000;
    cnt = 5'h00;
  end
  ////////////////////////////////////////
  // Internal clock: bit taken on each rising clock inside the frame
  always @(posedge ref_clk) begin
    clk_q <= data_out[9];
    take = data_out[9] && !clk_q && (data_out[10] ^ mark_inv);
    if (int_mode) begin
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      valid <= take && cnt == 5'h0F;
      if (take) begin
        word <= {word[14:0], data_out[8]};
        cnt <= (cnt == 5'h0F) ? 5'h00 : cnt + 5'h01;
      end
    end
  end
  // Undriven pins read back inverted, so a released line never matches
  task automatic par_read();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    word <= data_out ^ ~data_oe;
    valid <= 1'b1;
    @(posedge ref_clk);
    valid <= 1'b0;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
  // External clock, 160 ns period, idle at the inactive level
  task automatic ext_read(input logic inv, input int n, input logic report);
    #7 sclk = inv;
    repeat (3) begin
      #80 sclk = !sclk;
      #80 sclk = !sclk;
    end
    cs_n = 1'b0;
    rd_n = 1'b0;
    #400;
    // Sample 120 ns after the active edge: a wrong-edge shift is not yet visible
    repeat (n) begin
      word = {word[14:0], data_out[8] ^ ~data_oe[8]};
      #40 sclk = !inv;
      #80 sclk = inv;
      #40;
    end
    valid = report;
    @(posedge ref_clk);
    #1 valid = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
endmodule

// ==== verif/adc_conversion_and_output_port_tb_top.sv ====
// Bench for adc_port: reset, bus, parallel and serial reads, overrun, power-down.
// Assumes host_model on the pins and the checker bound in its own file.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module adc_conversion_and_output_port_tb_top import adc_pkg::*; ;
  logic ref_clk, srst, hsel, hwrite, hreadyout, hresp, busy, sample_hold, low_power;
  logic ref_enable, ref_buffer_enable, convert_start_n, chain_in, cs_n, rd_n, sclk;
  logic valid, int_mode, mark_inv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] sar_code, data_out, data_oe, word, exp_w, got_exp;
  logic [15:0] exp_q[$];
  int mismatches, checks_done, ovr_seen, k;
  integer seed = 32'h3A904031;
  // Core clock, 50 MHz
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  adc_port adc_port_i (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .convert_start_n, .cs_n, .rd_n,
    .read_timing_or_chain_in(chain_in), .sclk_in(sclk), .sar_code, .data_out, .data_oe,
    .busy, .sample_hold, .ref_enable, .ref_buffer_enable, .low_power);
  host_model host_model_i (.ref_clk, .int_mode, .mark_inv, .data_out, .data_oe, .cs_n, .rd_n, .sclk,
    .word, .valid);
  ////////////////////////////////////////
  // Single word transfer; hready is the slave's own hreadyout
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // One conversion on a random code; early holds start low before acquisition ends
  task automatic conv(input logic early, output logic [15:0] s);
    int i;
    s = 16'($random(seed));
    @(posedge ref_clk);
    sar_code <= s;
    if (!early) begin
      repeat (90) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("held for start edge", 1'b0, busy)
      @(posedge ref_clk);
    end
    convert_start_n <= 1'b0;
    for (i = 0; i < 100 && busy !== 1'b1; i++) @(negedge ref_clk);
    `CHK("busy rise", 1'b1, busy)
    @(posedge ref_clk);
    convert_start_n <= 1'b1;
    for (i = 0; i < 500 && busy !== 1'b0; i++) @(negedge ref_clk);
    `CHK("busy fall", 1'b0, busy)
  endtask
  // Bounded wait until every noted result has been seen
  task automatic drain();
    int i;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge ref_clk);
    `CHK("results delivered", 0, exp_q.size())
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Oldest note against each delivered word; overrun pin cycles counted
  always @(posedge ref_clk) begin
    if (data_out[11] === 1'b1) ovr_seen++;
    if (valid === 1'b1) begin
      // A word with no note left is forced to mismatch
      got_exp = (exp_q.size() != 0) ? exp_q.pop_front() : ~word;
      `CHK("result word", got_exp, word)
    end
  end
  // Watchdog: the tests need about 5300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    {hsize, sar_code, convert_start_n, chain_in, int_mode, mark_inv} = {3'b010, 16'h0000, 4'b1000};
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    `CHK("reference on", 1'b1, ref_enable)
    `CHK("buffer on", 1'b1, ref_buffer_enable)
    bus(1'b0, 32'(CTRL_OFS), 32'h0);
    `CHK("control reset", 32'h0, rd)
    bus(1'b0, 32'h0000000C, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("idle drivers", 16'h0000, data_oe)
    $display("test reset done");
    for (k = 0; k < 2; k++) begin
      conv(k == 0, exp_w);
      exp_q.push_back(exp_w);
      host_model_i.par_read();
    end
    drain();
    $display("test parallel done");
    for (k = 0; k < 2; k++) begin
      bus(1'b1, 32'(CTRL_OFS), 32'h3 | 32'(k << 2));
      chain_in <= 1'b1;
      conv(1'b0, exp_w);
      exp_q.push_back({exp_w[14:0], 1'b1});
      host_model_i.ext_read(k[0], 17, 1'b1);
    end
    drain();
    $display("test external serial done");
    conv(1'b0, exp_w);
    host_model_i.ext_read(1'b1, 8, 1'b0);
    ovr_seen = 0;
    conv(1'b0, exp_w);
    repeat (8) @(negedge ref_clk);
    `CHK("overrun pulse cycles", 1, ovr_seen)
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    `CHK("overrun count", 8'h01, rd[15:8])
    $display("test overrun done");
    int_mode <= 1'b1;
    // Read after conversion, then read during the next one with the marker inverted
    for (k = 0; k < 2; k++) begin
      bus(1'b1, 32'(CTRL_OFS), 32'h1 | 32'(k << 3));
      chain_in <= k[0];
      mark_inv <= k[0];
      if (k == 1) exp_q.push_back(exp_w);
      conv(1'b0, exp_w);
      if (k == 0) exp_q.push_back(exp_w);
      drain();
    end
    int_mode <= 1'b0;
    $display("test internal serial done");
    // Power-down raised mid-conversion must let that conversion run out
    @(posedge ref_clk);
    convert_start_n <= 1'b0;
    for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge ref_clk);
    bus(1'b1, 32'(CTRL_OFS), 32'h70);
    repeat (100) @(negedge ref_clk);
    `CHK("conversion kept running", 1'b1, busy)
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge ref_clk);
    repeat (120) @(negedge ref_clk);
    `CHK("low power", 1'b1, low_power)
    `CHK("no conversion", 1'b0, busy)
    `CHK("reference off", 1'b0, ref_enable)
    `CHK("buffer off", 1'b0, ref_buffer_enable)
    bus(1'b1, 32'(CTRL_OFS), 32'h0);
    repeat (120) @(negedge ref_clk);
    `CHK("awake", 1'b0, low_power)
    $display("test power-down done");
    // Reset in mid-conversion must drop busy at once
    for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge ref_clk);
    `CHK("busy before reset", 1'b1, busy)
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    `CHK("conversion aborted", 1'b0, busy)
    $display("test reset abort done");
    print_verdict();
  end
endmodule
